// *** fbwm_pkg.sv ***
// Constants, types and helpers shared by the write-mask and clear unit
// Notes on behaviour
// - In index mode only, index mask bits enable writing each index bit.
// - Per-buffer command sets RGBA enables of one selected draw buffer.
// - A selector naming several buffers applies its mask to all of them.
// - Global command loads the same RGBA enables into every draw buffer.
// - Per-buffer command with index above last draw buffer flags error, no change.
// - After reset all index bits and all component enables are set.
// - Depth enable set by non-zero argument, cleared by zero; gates depth writes.
// - Low stencil mask bits enable writing each stencil bit.
// - Faced command updates front, back or both; plain command loads both.
// - Front-facing fragments use front stencil mask, back-facing use back mask.
// - Stencil clear always uses the front stencil mask.
// - Reset: index and stencil masks all ones, depth and RGBA enables set.
// - With multisampling, masks gate samples; resolved colour ignores colour enables.
// - Clear bit set selects accum, colour, depth, stencil; zero clears nothing.
// - Clear bit set with undefined bits flags invalid-value error.
// - Clear index keeps integer part masked to framebuffer index width.
// - Depth clear clamped to zero..one; fixed converted, float passed unconverted.
// - Stencil clear masked to stencil width; accum clear clamped to minus one..one.
// - Clear applies only write masks here; absent buffers are left untouched.
// - Unorm clamps colour to zero..one, snorm to minus one..one, then converts.
// - Reset clear values: colour, accum, index, stencil zero; depth one.
// - A colour output whose selector names no buffer is not written; with multisampling its sample write is still issued.
package fbwm_pkg;

    // ****************************************
    // Sizes
    // ****************************************
    localparam int NUM_DRAW      = 4;
    localparam int INDEX_BITS    = 8;
    localparam int STENCIL_BITS  = 8;
    localparam int FIX_BITS      = 16;
    localparam int ADDR_BITS     = 8;

    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [7:0] OFS_INDEX_MASK   = 8'h00;
    localparam logic [7:0] OFS_ALL_COMP     = 8'h04;
    localparam logic [7:0] OFS_BUF_COMP     = 8'h08;
    localparam logic [7:0] OFS_DEPTH_WE     = 8'h0C;
    localparam logic [7:0] OFS_STENCIL_BOTH = 8'h10;
    localparam logic [7:0] OFS_STENCIL_FACE = 8'h14;
    localparam logic [7:0] OFS_CLR_RG       = 8'h18;
    localparam logic [7:0] OFS_CLR_BA       = 8'h1C;
    localparam logic [7:0] OFS_CLR_INDEX    = 8'h20;
    localparam logic [7:0] OFS_CLR_DEPTH    = 8'h24;
    localparam logic [7:0] OFS_CLR_STENCIL  = 8'h28;
    localparam logic [7:0] OFS_ACC_RG       = 8'h2C;
    localparam logic [7:0] OFS_ACC_BA       = 8'h30;
    localparam logic [7:0] OFS_DRAW_SEL     = 8'h34;
    localparam logic [7:0] OFS_CONFIG       = 8'h38;
    localparam logic [7:0] OFS_CLEAR        = 8'h3C;
    localparam logic [7:0] OFS_STATUS       = 8'h40;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int BUF_IDX_LSB    = 8;
    localparam int FACE_LSB       = 16;
    localparam int CFG_INDEX_MODE = 0;
    localparam int CFG_MS_PRESENT = 1;
    localparam int CFG_DEPTH_FLT  = 2;
    localparam int CFG_BUF_LSB    = 4;
    localparam int CFG_DEPTH_PRES = 8;
    localparam int CFG_STEN_PRES  = 9;
    localparam int CFG_ACC_PRES   = 10;
    localparam int CFG_FMT_LSB    = 16;
    localparam int CLR_ACCUM      = 0;
    localparam int CLR_COLOUR     = 1;
    localparam int CLR_DEPTH      = 2;
    localparam int CLR_STENCIL    = 3;
    localparam logic [31:0] CLR_DEFINED = 32'h0000000F;

    // ****************************************
    // Reset values and fixed-point figures (Q2.14)
    // ****************************************
    localparam logic [15:0] FIX_ONE        = 16'h4000;
    localparam logic [15:0] FIX_MINUS_ONE  = 16'hC000;
    localparam logic [15:0] FIX_ZERO       = 16'h0000;
    localparam logic [15:0] FIX_HALF       = 16'h2000;
    localparam logic [15:0] RST_CLR_DEPTH  = 16'h4000;
    localparam logic [31:0] RST_CONFIG     = 32'h000007F0;
    localparam logic [15:0] RST_DRAW_SEL   = 16'h0006;

    // ****************************************
    // Enumerations
    // ****************************************
    typedef enum logic [3:0] {
        SEL_NONE        = 4'h0,
        SEL_FRONT_LEFT  = 4'h1,
        SEL_FRONT_RIGHT = 4'h2,
        SEL_BACK_LEFT   = 4'h3,
        SEL_BACK_RIGHT  = 4'h4,
        SEL_FRONT       = 4'h5,
        SEL_BACK        = 4'h6,
        SEL_LEFT        = 4'h7,
        SEL_RIGHT       = 4'h8,
        SEL_FRONT_BACK  = 4'h9
    } fbwm_sel_type;

    typedef enum logic [1:0] {
        FACE_FRONT = 2'h1,
        FACE_BACK  = 2'h2,
        FACE_BOTH  = 2'h3
    } fbwm_face_type;

    typedef enum logic [1:0] {
        FMT_UNORM = 2'h0,
        FMT_SNORM = 2'h1,
        FMT_INT   = 2'h2
    } fbwm_fmt_type;

    // ****************************************
    // Carriers
    // ****************************************
    typedef struct packed {
        logic        valid;
        logic        front_facing;
        logic [1:0]  out_idx;
        logic        resolve;
        logic [31:0] rgba;
        logic [7:0]  index;
        logic [15:0] depth;
        logic [7:0]  stencil;
    } fbwm_frag_type;

    typedef struct packed {
        logic        valid;
        logic        sample;
        logic [3:0]  bufs;
        logic [31:0] rgba;
        logic [3:0]  comp_en;
        logic [7:0]  index;
        logic [7:0]  index_mask;
        logic [15:0] depth;
        logic        depth_we;
        logic [7:0]  stencil;
        logic [7:0]  stencil_mask;
    } fbwm_write_type;

    typedef struct packed {
        logic             valid;
        logic [3:0][3:0]  bufs;
        logic [3:0][3:0]  comp_en;
        logic [3:0][31:0] rgba;
        logic [7:0]       index;
        logic [7:0]       index_mask;
        logic [15:0]      depth;
        logic             depth_we;
        logic [7:0]       stencil;
        logic [7:0]       stencil_mask;
        logic [3:0][15:0] accum;
        logic             accum_we;
    } fbwm_clear_type;

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [15:0] fbwm_clamp(input logic [15:0] v,
                                               input logic [15:0] lo,
                                               input logic [15:0] hi);
        if ($signed(v) < $signed(lo))
            return lo;
        else if ($signed(v) > $signed(hi))
            return hi;
        else
            return v;
    endfunction

    // Buffer set bits: 0 front left, 1 front right, 2 back left, 3 back right
    function automatic logic [3:0] fbwm_decode(input logic [3:0] sel);
        case (sel)
            SEL_FRONT_LEFT:  return 4'h1;
            SEL_FRONT_RIGHT: return 4'h2;
            SEL_BACK_LEFT:   return 4'h4;
            SEL_BACK_RIGHT:  return 4'h8;
            SEL_FRONT:       return 4'h3;
            SEL_BACK:        return 4'hC;
            SEL_LEFT:        return 4'h5;
            SEL_RIGHT:       return 4'hA;
            SEL_FRONT_BACK:  return 4'hF;
            default:         return 4'h0;
        endcase
    endfunction

endpackage

// *** fbwm_unit.sv ***
// Framebuffer write-mask and clear unit
//
// Design decisions made here: the address map and the plain strobed port.
`timescale 1ns/1ns
module fbwm_unit
    import fbwm_pkg::*;
(
    input  wire logic           clk_in,
    input  wire logic           srst_in,
    input  wire logic [7:0]     addr_in,
    input  wire logic [31:0]    wdata_in,
    input  wire logic           wr_in,
    input  wire logic           rd_in,
    output logic [31:0]         rdata_out,
    input  wire fbwm_frag_type  frag_in,
    output fbwm_write_type      write_out,
    output fbwm_clear_type      clear_out,
    output logic                error_out
);

    // ****************************************
    // Mask and clear state
    // ****************************************
    logic [7:0]       index_mask;
    logic [3:0][3:0]  comp_en;
    logic             depth_we;
    logic [7:0]       stencil_front;
    logic [7:0]       stencil_back;
    logic [3:0][15:0] clr_rgba;
    logic [7:0]       clr_index;
    logic [15:0]      clr_depth;
    logic [7:0]       clr_stencil;
    logic [3:0][15:0] clr_accum;
    logic [15:0]      draw_sel;
    logic [31:0]      config_reg;
    logic             err_sticky;

    logic             wr_buf_comp;
    logic             buf_idx_bad;
    logic             wr_face;
    logic             face_bad;
    logic             wr_clear;
    logic             clear_bad;
    logic             err_event;
    logic [1:0]       buf_idx;

    assign wr_buf_comp = wr_in && addr_in == OFS_BUF_COMP;
    assign buf_idx_bad = wdata_in[15:BUF_IDX_LSB] > 8'(NUM_DRAW - 1);
    assign buf_idx     = wdata_in[BUF_IDX_LSB+1:BUF_IDX_LSB];
    assign wr_face     = wr_in && addr_in == OFS_STENCIL_FACE;
    assign face_bad    = wdata_in[FACE_LSB+1:FACE_LSB] == 2'h0;
    assign wr_clear    = wr_in && addr_in == OFS_CLEAR;
    assign clear_bad   = (wdata_in & ~CLR_DEFINED) != 32'h00000000;
    assign err_event   = (wr_buf_comp && buf_idx_bad)
                      || (wr_face && face_bad)
                      || (wr_clear && clear_bad);

    // ****************************************
    // Colour component enables
    // ****************************************
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            comp_en <= {NUM_DRAW{4'hF}};
        end else if (wr_in && addr_in == OFS_ALL_COMP) begin
            comp_en <= {NUM_DRAW{wdata_in[3:0]}};
        end else if (wr_buf_comp && !buf_idx_bad) begin
            comp_en[buf_idx] <= wdata_in[3:0];
        end
    end

    // ****************************************
    // Index, depth and stencil masks
    // ****************************************
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            index_mask <= 8'hFF;
            depth_we   <= 1'b1;
        end else if (wr_in) begin
            if (addr_in == OFS_INDEX_MASK)
                index_mask <= wdata_in[INDEX_BITS-1:0];
            if (addr_in == OFS_DEPTH_WE)
                depth_we <= wdata_in != 32'h00000000;
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            stencil_front <= 8'hFF;
            stencil_back  <= 8'hFF;
        end else if (wr_in && addr_in == OFS_STENCIL_BOTH) begin
            stencil_front <= wdata_in[STENCIL_BITS-1:0];
            stencil_back  <= wdata_in[STENCIL_BITS-1:0];
        end else if (wr_face && !face_bad) begin
            if (wdata_in[FACE_LSB])
                stencil_front <= wdata_in[STENCIL_BITS-1:0];
            if (wdata_in[FACE_LSB+1])
                stencil_back <= wdata_in[STENCIL_BITS-1:0];
        end
    end

    // ****************************************
    // Clear values
    // ****************************************
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            clr_rgba    <= '0;
            clr_index   <= 8'h00;
            clr_depth   <= RST_CLR_DEPTH;
            clr_stencil <= 8'h00;
            clr_accum   <= '0;
        end else if (wr_in) begin
            case (addr_in)
                OFS_CLR_RG: begin
                    clr_rgba[0] <= wdata_in[15:0];
                    clr_rgba[1] <= wdata_in[31:16];
                end
                OFS_CLR_BA: begin
                    clr_rgba[2] <= wdata_in[15:0];
                    clr_rgba[3] <= wdata_in[31:16];
                end
                OFS_CLR_INDEX: begin
                    clr_index <= wdata_in[16+INDEX_BITS-1:16];
                end
                OFS_CLR_DEPTH: begin
                    clr_depth <= fbwm_clamp(wdata_in[15:0], FIX_ZERO, FIX_ONE);
                end
                OFS_CLR_STENCIL: begin
                    clr_stencil <= wdata_in[STENCIL_BITS-1:0];
                end
                OFS_ACC_RG: begin
                    clr_accum[0] <= fbwm_clamp(wdata_in[15:0], FIX_MINUS_ONE, FIX_ONE);
                    clr_accum[1] <= fbwm_clamp(wdata_in[31:16], FIX_MINUS_ONE, FIX_ONE);
                end
                OFS_ACC_BA: begin
                    clr_accum[2] <= fbwm_clamp(wdata_in[15:0], FIX_MINUS_ONE, FIX_ONE);
                    clr_accum[3] <= fbwm_clamp(wdata_in[31:16], FIX_MINUS_ONE, FIX_ONE);
                end
                default: begin
                end
            endcase
        end
    end

    // ****************************************
    // Configuration, selectors and error status
    // ****************************************
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            draw_sel   <= RST_DRAW_SEL;
            config_reg <= RST_CONFIG;
        end else if (wr_in) begin
            if (addr_in == OFS_DRAW_SEL)
                draw_sel <= wdata_in[15:0];
            if (addr_in == OFS_CONFIG)
                config_reg <= wdata_in;
        end
    end

    // A new error in the clearing cycle keeps the flag set
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            err_sticky <= 1'b0;
            error_out  <= 1'b0;
        end else begin
            error_out <= err_event;
            if (err_event)
                err_sticky <= 1'b1;
            else if (wr_in && addr_in == OFS_STATUS && wdata_in[0])
                err_sticky <= 1'b0;
        end
    end

    // ****************************************
    // Register read
    // ****************************************
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            rdata_out <= 32'h00000000;
        end else if (rd_in) begin
            case (addr_in)
                OFS_INDEX_MASK:   rdata_out <= {24'h000000, index_mask};
                OFS_ALL_COMP:     rdata_out <= {28'h0000000, comp_en[0]};
                OFS_BUF_COMP:     rdata_out <= {16'h0000, comp_en};
                OFS_DEPTH_WE:     rdata_out <= {31'h00000000, depth_we};
                OFS_STENCIL_BOTH: rdata_out <= {24'h000000, stencil_front};
                OFS_STENCIL_FACE: rdata_out <= {16'h0000, stencil_back, stencil_front};
                OFS_CLR_RG:       rdata_out <= {clr_rgba[1], clr_rgba[0]};
                OFS_CLR_BA:       rdata_out <= {clr_rgba[3], clr_rgba[2]};
                OFS_CLR_INDEX:    rdata_out <= {8'h00, clr_index, 16'h0000};
                OFS_CLR_DEPTH:    rdata_out <= {16'h0000, clr_depth};
                OFS_CLR_STENCIL:  rdata_out <= {24'h000000, clr_stencil};
                OFS_ACC_RG:       rdata_out <= {clr_accum[1], clr_accum[0]};
                OFS_ACC_BA:       rdata_out <= {clr_accum[3], clr_accum[2]};
                OFS_DRAW_SEL:     rdata_out <= {16'h0000, draw_sel};
                OFS_CONFIG:       rdata_out <= config_reg;
                OFS_STATUS:       rdata_out <= {31'h00000000, err_sticky};
                default:          rdata_out <= 32'h00000000;
            endcase
        end else begin
            rdata_out <= 32'h00000000;
        end
    end

    // ****************************************
    // Per draw buffer selection and clear colour
    // ****************************************
    logic             index_mode;
    logic             ms_present;
    logic [3:0]       buf_present;
    logic [3:0][3:0]  sel_bufs;
    logic [3:0][31:0] clr_conv;

    assign index_mode  = config_reg[CFG_INDEX_MODE];
    assign ms_present  = config_reg[CFG_MS_PRESENT];
    assign buf_present = config_reg[CFG_BUF_LSB+3:CFG_BUF_LSB];

    genvar gi;
    generate
        for (gi = 0; gi < NUM_DRAW; gi++) begin : g_draw
            logic [1:0] fmt;
            assign fmt = config_reg[CFG_FMT_LSB+2*gi+1:CFG_FMT_LSB+2*gi];
            // Absent buffers and an empty selector give no targets
            assign sel_bufs[gi] = fbwm_decode(draw_sel[4*gi+3:4*gi]) & buf_present;

            for (genvar ci = 0; ci < 4; ci++) begin : g_comp
                logic [15:0] cu;
                logic [15:0] cs;
                logic [31:0] pu;
                logic [31:0] ps;
                assign cu = fbwm_clamp(clr_rgba[ci], FIX_ZERO, FIX_ONE);
                assign cs = fbwm_clamp(clr_rgba[ci], FIX_MINUS_ONE, FIX_ONE);
                assign pu = 32'(cu) * 32'd255 + 32'(FIX_HALF);
                assign ps = 32'($signed(cs) * 32'sd127 + $signed({16'h0000, FIX_HALF}));
                always_comb begin
                    case (fmt)
                        FMT_UNORM: clr_conv[gi][8*ci+7:8*ci] = pu[21:14];
                        FMT_SNORM: clr_conv[gi][8*ci+7:8*ci] = ps[21:14];
                        default:   clr_conv[gi][8*ci+7:8*ci] = clr_rgba[ci][7:0];
                    endcase
                end
            end
        end
    endgenerate

    // ****************************************
    // Fragment write masking
    // ****************************************
    logic [3:0] frag_bufs;
    logic       frag_sample;
    logic       frag_resolve;

    assign frag_bufs    = sel_bufs[frag_in.out_idx];
    assign frag_resolve = ms_present && frag_in.resolve;
    assign frag_sample  = ms_present && !frag_in.resolve;

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            write_out <= '0;
        end else begin
            write_out.valid   <= frag_in.valid
                              && (frag_sample || frag_bufs != 4'h0);
            write_out.sample  <= frag_sample;
            write_out.bufs    <= frag_sample ? 4'h0 : frag_bufs;
            write_out.rgba    <= frag_in.rgba;
            write_out.index   <= frag_in.index;
            write_out.depth   <= frag_in.depth;
            write_out.stencil <= frag_in.stencil;
            if (frag_resolve) begin
                // Resolved colour replaces the buffers regardless of enables
                write_out.comp_en      <= index_mode ? 4'h0 : 4'hF;
                write_out.index_mask   <= index_mode ? 8'hFF : 8'h00;
                write_out.depth_we     <= 1'b0;
                write_out.stencil_mask <= 8'h00;
            end else begin
                write_out.comp_en    <= index_mode ? 4'h0 : comp_en[frag_in.out_idx];
                write_out.index_mask <= index_mode ? index_mask : 8'h00;
                write_out.depth_we   <= depth_we && config_reg[CFG_DEPTH_PRES];
                write_out.stencil_mask <= !config_reg[CFG_STEN_PRES] ? 8'h00 :
                                          frag_in.front_facing ? stencil_front :
                                          stencil_back;
            end
        end
    end

    // ****************************************
    // Clear execution
    // ****************************************
    logic        do_accum;
    logic        do_colour;
    logic        do_depth;
    logic        do_stencil;
    logic [31:0] depth_fix;

    assign do_accum   = wdata_in[CLR_ACCUM] && config_reg[CFG_ACC_PRES];
    assign do_colour  = wdata_in[CLR_COLOUR];
    assign do_depth   = wdata_in[CLR_DEPTH] && config_reg[CFG_DEPTH_PRES];
    assign do_stencil = wdata_in[CLR_STENCIL] && config_reg[CFG_STEN_PRES];
    assign depth_fix  = 32'(clr_depth) * 32'd65535 + 32'(FIX_HALF);

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            clear_out <= '0;
        end else begin
            clear_out.valid <= wr_clear && !clear_bad
                            && wdata_in[3:0] != 4'h0;
            for (int i = 0; i < NUM_DRAW; i++) begin
                clear_out.bufs[i]    <= (do_colour && !index_mode) ? sel_bufs[i] : 4'h0;
                clear_out.comp_en[i] <= comp_en[i];
                clear_out.rgba[i]    <= clr_conv[i];
            end
            clear_out.index      <= clr_index;
            clear_out.index_mask <= (do_colour && index_mode) ? index_mask : 8'h00;
            clear_out.depth      <= config_reg[CFG_DEPTH_FLT] ? clr_depth
                                                              : depth_fix[29:14];
            clear_out.depth_we   <= do_depth && depth_we;
            clear_out.stencil    <= clr_stencil;
            clear_out.stencil_mask <= do_stencil ? stencil_front : 8'h00;
            clear_out.accum      <= clr_accum;
            clear_out.accum_we   <= do_accum;
        end
    end

endmodule

// *** fbwm_unit_properties.sv ***
// Port assertions for the write-mask and clear unit
`timescale 1ns/1ns
module fbwm_unit_properties
    import fbwm_pkg::*;
(
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic [7:0] addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [31:0] rdata_out,
    input wire fbwm_frag_type frag_in,
    input wire fbwm_write_type write_out,
    input wire fbwm_clear_type clear_out,
    input wire logic error_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (srst_in);
    sequence s_frag(a);
        wr_in && addr_in == a ##1 !wr_in ##1 frag_in.valid && !frag_in.resolve && !wr_in;
    endsequence
    sequence s_front_clr;
        wr_in && addr_in == OFS_STENCIL_FACE && wdata_in[17:16] == 2'h1
        ##1 wr_in && addr_in == OFS_CLEAR && wdata_in[31:3] == 29'h1;
    endsequence
    a_bad_clear: assert property (wr_in && addr_in == OFS_CLEAR && |wdata_in[31:4]
        |=> error_out && !clear_out.valid) else $error("bad clear");
    a_zero_clear: assert property (wr_in && addr_in == OFS_CLEAR && wdata_in == 32'h0
        |=> !clear_out.valid && !error_out) else $error("empty clear");
    a_clear_go: assert property (wr_in && addr_in == OFS_CLEAR && wdata_in[31:3] == 29'h1
        |=> clear_out.valid) else $error("clear lost");
    a_bad_index: assert property (wr_in && addr_in == OFS_BUF_COMP && wdata_in[15:8] > 8'h03
        |=> error_out) else $error("bad index");
    a_depth_gate: assert property (s_frag(OFS_DEPTH_WE) |=> !write_out.valid
        || write_out.depth_we == |$past(wdata_in, 3)) else $error("depth enable");
    a_all_comp: assert property (s_frag(OFS_ALL_COMP) |=> !write_out.valid
        || write_out.comp_en == $past(wdata_in[3:0], 3)) else $error("component enables");
    a_front_clr: assert property (s_front_clr |=>
        clear_out.stencil_mask == $past(wdata_in[7:0], 2)) else $error("clear mask");
    a_rdata_idle: assert property (!rd_in |=> rdata_out == 32'h0) else $error("read data");
endmodule
bind fbwm_unit fbwm_unit_properties i_props (.*);

// *** fbwm_frag_src.sv ***
// Fragment source model feeding the unit
`timescale 1ns/1ns
module fbwm_frag_src
    import fbwm_pkg::*;
(
    input  wire logic       clk_in,
    input  wire logic       go_in,
    input  wire logic [2:0] face_idx_in,
    input  wire logic       resolve_in,
    output fbwm_frag_type   frag_out
);
    logic [7:0] cnt = 8'h00;
    initial frag_out = '0;
    always @(posedge clk_in) begin
        cnt <= cnt + 8'h01;
        // Payload changes every cycle so stale data never looks valid
        frag_out <= {go_in, face_idx_in, resolve_in, {4{cnt}}, cnt, {2{cnt}}, cnt};
    end
endmodule

// *** tb_fb_write_mask_and_clear.sv ***
// Self-checking testbench for the write-mask and clear unit
`timescale 1ns/1ns
module tb_fb_write_mask_and_clear;
    import fbwm_pkg::*;
    logic clk_in = 1'b0, srst_in = 1'b1, wr_in = 1'b0, rd_in = 1'b0;
    logic rd_q = 1'b0, go = 1'b0, rs = 1'b0, error_out;
    logic [2:0] fi = 3'h4;
    logic [7:0] addr_in = 8'h00;
    logic [15:0] r = 16'hA7DA;
    logic [31:0] wdata_in = 32'h0, rdata_out, expq[$], wr_seen, clr_seen;
    int n_mismatch = 0, tests_run = 0;
    fbwm_frag_type frag_in;
    fbwm_write_type write_out;
    fbwm_clear_type clear_out;
    logic [7:0] ra[7] = '{OFS_INDEX_MASK, OFS_BUF_COMP, OFS_DEPTH_WE, OFS_STENCIL_FACE,
        OFS_CLR_DEPTH, OFS_CLR_STENCIL, 8'h44};
    logic [31:0] rv[7] = '{32'hFF, 32'hFFFF, 32'h1, 32'hFFFF, 32'h4000, 32'h0, 32'h0};
    always #2 clk_in = ~clk_in;
    fbwm_frag_src i_src (.clk_in(clk_in), .go_in(go), .face_idx_in(fi), .resolve_in(rs),
        .frag_out(frag_in));
    fbwm_unit i_dut (.*);
    function automatic logic [15:0] lfsr(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction
    function automatic logic [31:0] take();
        if (expq.size() == 0)
            return 32'hX;
        return expq.pop_front();
    endfunction
    task check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    assign wr_seen = {write_out.sample, write_out.index_mask, 6'h00, write_out.depth_we,
        write_out.bufs, write_out.comp_en, write_out.stencil_mask};
    assign clr_seen = {clear_out.stencil_mask, clear_out.depth, 2'h0, clear_out.accum_we,
        clear_out.bufs[0], clear_out.depth_we};
    always @(posedge clk_in) rd_q <= rd_in;
    // Results are taken in a fixed order: error, read, fragment write, clear
    always @(negedge clk_in) if (!srst_in) begin
        if (error_out !== 1'b0) check({32{error_out}}, take());
        if (rd_q) check(rdata_out, take());
        if (write_out.valid !== 1'b0) check(wr_seen, take());
        if (clear_out.valid !== 1'b0) check(clr_seen, take());
    end
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        if (!w) expq.push_back(d);
        addr_in <= a;
        wdata_in <= w ? d : 32'h0;
        wr_in <= w;
        rd_in <= !w;
        @(posedge clk_in);
    endtask
    task frag(input logic [2:0] f);
        wr_in <= 1'b0;
        rd_in <= 1'b0;
        go <= 1'b1;
        fi <= f;
        @(posedge clk_in);
        go <= 1'b0;
        repeat (2) @(posedge clk_in);
    endtask
    task test_done;
        if (expq.size() != 0) n_mismatch++;
        $display("Compared %0d, mismatched %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clk_in);
        srst_in <= 1'b0;
        @(posedge clk_in);
        foreach (ra[k]) bus(1'b0, ra[k], rv[k]);
        expq.push_back(32'h0001CFFF);
        frag(3'h4);
        frag(3'h5);
        expq.push_back(32'hFFFFFFFF);
        bus(1'b1, OFS_BUF_COMP, 32'h00000400);
        bus(1'b0, OFS_BUF_COMP, 32'h0000FFFF);
        r = lfsr(r);
        bus(1'b1, OFS_ALL_COMP, {28'h0, r[3:0]});
        expq.push_back({16'h0001, 4'hC, r[3:0], 8'hFF});
        frag(3'h4);
        bus(1'b1, OFS_BUF_COMP, 32'h00000006);
        expq.push_back(32'h0001C6FF);
        frag(3'h4);
        r = lfsr(r);
        bus(1'b1, OFS_STENCIL_FACE, {16'h0002, 8'h00, r[7:0]});
        expq.push_back({16'h0001, 8'hC6, r[7:0]});
        frag(3'h0);
        expq.push_back(32'hFFFFFF01);
        bus(1'b1, OFS_CLEAR, 32'h0000000C);
        bus(1'b1, OFS_CLR_DEPTH, 32'h00007000);
        bus(1'b0, OFS_CLR_DEPTH, 32'h00004000);
        bus(1'b1, OFS_STENCIL_FACE, 32'h0001003C);
        expq.push_back(32'h3CFFFF01);
        bus(1'b1, OFS_CLEAR, 32'h0000000C);
        expq.push_back(32'hFFFFFFFF);
        bus(1'b1, OFS_CLEAR, 32'h0000001C);
        bus(1'b1, OFS_CLEAR, 32'h00000000);
        bus(1'b1, OFS_DEPTH_WE, 32'h00000000);
        expq.push_back(32'h0000C63C);
        frag(3'h4);
        expq.push_back(32'h00FFFF38);
        bus(1'b1, OFS_CLEAR, 32'h00000003);
        bus(1'b1, OFS_CONFIG, 32'h000007F2);
        bus(1'b1, OFS_ALL_COMP, 32'h00000000);
        expq.push_back(32'h0000CF00);
        rs <= 1'b1;
        frag(3'h4);
        rs <= 1'b0;
        expq.push_back(32'h8000003C);
        frag(3'h4);
        bus(1'b1, OFS_CONFIG, 32'h000007F1);
        r = lfsr(r);
        bus(1'b1, OFS_INDEX_MASK, {24'h0, r[7:0]});
        expq.push_back({1'b0, r[7:0], 23'h00C03C});
        frag(3'h4);
        test_done();
    end
endmodule
